// File: design/spm_top.sv
`timescale 1ns/10ps
// Summary of operation
// RL1 - Each transfer moves eight bits out and eight in together, MSB first.
// RL2 - The master makes every serial clock pulse; the slave answers on it.
// RL3 - Output bits leave in order starting from the shift register MSB.
// RL4 - After the eighth bit the byte goes to the buffer; set full and irq flags. Here this waits in SPM_DONE while the receive FIFO is full.
// RL5 - A buffer write during a transfer is dropped and sets the sticky collision flag.
// RL6 - Reading the buffer clears the buffer-full flag.
// RL7 - The shift register is reached only through the buffer register. The receive FIFO here also takes each byte straight from it.
// RL8 - In master mode a buffer write starts the transfer at once.
// RL9 - Software resets or reconfigures by clearing enable, rewriting control, re-enabling.
// RL10 - When enabled in master mode the three serial pins belong to the port.
// RL11 - Software sets data-in as input, data-out and clock as outputs.
// RL12 - Clock source is system clock over 4, 16, 64 or timer output over 2.
// RL13 - Idle clock level follows the polarity bit.
// RL14 - With clock-edge bit set, output data is valid before the first edge.
// RL15 - Sample-phase bit picks sampling at middle or end of each bit time.
// RL16 - With data-out turned to input, shifting in still runs at the set rate.
// RL17 - In sleep the transfer freezes and resumes from that point on wake.
// RL18 - The irq flag stays set until software clears it; buffer reads keep it.

// ----------------------------------------------------------------
// Receive byte FIFO
// ----------------------------------------------------------------
module spm_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic      [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0]         wp;
        logic [AW:0]         rp;
    } spm_fifo_st_t;

    spm_fifo_st_t cur;
    spm_fifo_st_t next_st;
    logic         full;
    logic         empty;

    // Pointer compare with wrap bit
    assign empty       = (cur.wp == cur.rp);
    assign full        = (cur.wp[AW-1:0] == cur.rp[AW-1:0]) && (cur.wp[AW] != cur.rp[AW]);
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = cur.mem[cur.rp[AW-1:0]];

    // Push and pop
    always_comb
    begin
        next_st = cur;
        if (in_valid_i && !full)
        begin
            next_st.mem[cur.wp[AW-1:0]] = in_data_i;
            next_st.wp                  = cur.wp + 1'b1;
        end
        if (out_ready_i && !empty)
        begin
            next_st.rp = cur.rp + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_st;
        end
    end
endmodule

// ----------------------------------------------------------------
// SPI master port with AXI4-Lite registers
// ----------------------------------------------------------------
module spm_top
    import spm_pkg::*;
(
    input  wire logic        CLOCK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic [7:0]  S_AWADDR_I,
    input  wire logic        S_AWVALID_I,
    output logic             S_AWREADY_O,
    input  wire logic [31:0] S_WDATA_I,
    input  wire logic [3:0]  S_WSTRB_I,
    input  wire logic        S_WVALID_I,
    output logic             S_WREADY_O,
    output logic [1:0]       S_BRESP_O,
    output logic             S_BVALID_O,
    input  wire logic        S_BREADY_I,
    input  wire logic [7:0]  S_ARADDR_I,
    input  wire logic        S_ARVALID_I,
    output logic             S_ARREADY_O,
    output logic [31:0]      S_RDATA_O,
    output logic [1:0]       S_RRESP_O,
    output logic             S_RVALID_O,
    input  wire logic        S_RREADY_I,
    input  wire logic        SLEEP_I,
    input  wire logic        TIMER_TWO_I,
    input  wire logic        SDI_I,
    output logic             SDO_O,
    output logic             SDO_OE_O,
    output logic             SCK_O,
    output logic             SCK_OE_O,
    output logic             RX_VALID_O,
    input  wire logic        RX_READY_I,
    output logic [7:0]       RX_DATA_O
);
    spm_regs_t  cur;
    spm_regs_t  next_st;
    logic       master;
    logic       busy;
    logic       half_tick;
    logic [5:0] half_len;
    logic       wr_fire;
    logic       rd_fire;
    logic       buf_wr;
    logic       fifo_ready;
    logic       fifo_push;

    // ----------------------------------------------------------------
    // Decode and handshakes
    // ----------------------------------------------------------------
    assign master      = (cur.cfg.mode[3:2] == 2'b00);
    assign busy        = (cur.state != SPM_IDLE);
    assign S_AWREADY_O = !cur.aw_vld;
    assign S_WREADY_O  = !cur.w_vld;
    assign S_ARREADY_O = !cur.rvalid;
    assign wr_fire     = cur.aw_vld && cur.w_vld && !cur.bvalid;
    assign rd_fire     = S_ARVALID_I && !cur.rvalid;
    assign buf_wr      = wr_fire && cur.w_lane0 && (cur.aw_addr == SPM_BUF_OFS);
    assign fifo_push   = (cur.state == SPM_DONE);

    // Half-period length per clock source
    always_comb
    begin
        unique case (cur.cfg.mode)
            SPM_MODE_DIV16: half_len = SPM_HALF_DIV16;
            SPM_MODE_DIV64: half_len = SPM_HALF_DIV64;
            default:        half_len = SPM_HALF_DIV4;
        endcase
    end

    // One-cycle enable per serial half period, frozen in sleep
    assign half_tick = (cur.state == SPM_SHIFT) && !SLEEP_I &&                        // RL17
                       ((cur.cfg.mode == SPM_MODE_TMR) ? TIMER_TWO_I                  // RL12
                                                       : (cur.div == half_len - 6'h01));

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        next_st = cur;

        // Write address and data are taken in either order
        if (S_AWVALID_I && !cur.aw_vld)
        begin
            next_st.aw_vld  = 1'b1;
            next_st.aw_addr = S_AWADDR_I;
        end
        if (S_WVALID_I && !cur.w_vld)
        begin
            next_st.w_vld   = 1'b1;
            next_st.w_data  = S_WDATA_I[7:0];
            next_st.w_lane0 = S_WSTRB_I[0];
        end
        if (cur.bvalid && S_BREADY_I)
        begin
            next_st.bvalid = 1'b0;
        end
        if (cur.rvalid && S_RREADY_I)
        begin
            next_st.rvalid = 1'b0;
        end

        // Register writes
        if (wr_fire)
        begin
            next_st.aw_vld = 1'b0;
            next_st.w_vld  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = SPM_RESP_OKAY;
            unique case (cur.aw_addr)
                SPM_CTRL_OFS:
                begin
                    if (cur.w_lane0)
                    begin
                        next_st.cfg.mode = cur.w_data[SPM_CTRL_MODE_LSB +: 4];
                        next_st.cfg.pol  = cur.w_data[SPM_CTRL_POL_BIT];
                        next_st.cfg.en   = cur.w_data[SPM_CTRL_EN_BIT];
                        if (!cur.w_data[SPM_CTRL_WRITE_COLLISION_FLAG_BIT])
                        begin
                            next_st.write_collision_flag = 1'b0;                // Cleared by writing zero
                        end
                    end
                end
                SPM_STAT_OFS:
                begin
                    if (cur.w_lane0)
                    begin
                        next_st.cfg.cke = cur.w_data[SPM_STAT_CKE_BIT];
                        next_st.cfg.sample_phase_bit = cur.w_data[SPM_STAT_SMP_BIT];
                    end
                end
                SPM_BUF_OFS:
                begin
                    if (cur.w_lane0 && busy)
                    begin
                        next_st.write_collision_flag = 1'b1;                    // RL5
                    end
                    else if (cur.w_lane0)
                    begin
                        next_st.buffer = cur.w_data;
                        if (cur.cfg.en && master)
                        begin
                            next_st.sr    = cur.w_data;         // RL7
                            next_st.state = SPM_SHIFT;          // RL8
                            next_st.half  = 4'h0;
                            next_st.div   = 6'h00;
                        end
                    end
                end
                SPM_FLAG_OFS:
                begin
                    if (cur.w_lane0 && cur.w_data[SPM_FLAG_IRQ_BIT])
                    begin
                        next_st.irq = 1'b0;                     // RL18
                    end
                end
                SPM_DIR_OFS:
                begin
                    if (cur.w_lane0)
                    begin
                        next_st.cfg.dir_sdo = cur.w_data[SPM_DIR_SDO_BIT];
                        next_st.cfg.dir_sck = cur.w_data[SPM_DIR_SCK_BIT];
                    end
                end
                default:
                begin
                    next_st.bresp = SPM_RESP_ERR;
                end
            endcase
        end

        // Register reads
        if (rd_fire)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = SPM_RESP_OKAY;
            unique case (S_ARADDR_I)
                SPM_CTRL_OFS: next_st.rdata = {cur.write_collision_flag, 1'b0, cur.cfg.en, cur.cfg.pol,
                                               cur.cfg.mode};
                SPM_STAT_OFS: next_st.rdata = {cur.cfg.sample_phase_bit, cur.cfg.cke, 5'h00, cur.bf};
                SPM_BUF_OFS:
                begin
                    next_st.rdata = cur.buffer;
                    next_st.bf    = 1'b0;                       // RL6
                end
                SPM_FLAG_OFS: next_st.rdata = {7'h00, cur.irq};
                SPM_DIR_OFS:  next_st.rdata = {6'h00, cur.cfg.dir_sck, cur.cfg.dir_sdo};
                default:
                begin
                    next_st.rdata = 8'h00;
                    next_st.rresp = SPM_RESP_ERR;
                end
            endcase
        end

        // Shift engine
        unique case (cur.state)
            SPM_IDLE:
            begin
                next_st.div = 6'h00;
            end
            SPM_SHIFT:
            begin
                if (!SLEEP_I)
                begin
                    next_st.div = half_tick ? 6'h00 : cur.div + 6'h01;
                end
                if (half_tick)
                begin
                    if (!cur.half[0] && !cur.cfg.sample_phase_bit)
                    begin
                        next_st.smp_bit = SDI_I;                // RL15
                    end
                    if (cur.half[0])
                    begin
                        // Out at the MSB, in at the LSB; runs whatever the pin direction
                        next_st.sr = {cur.sr[6:0],
                                      cur.cfg.sample_phase_bit ? SDI_I : cur.smp_bit}; // RL1 RL3 RL16
                    end
                    if (cur.half == SPM_LAST_HALF)
                    begin
                        next_st.state = SPM_DONE;
                    end
                    else
                    begin
                        next_st.half = cur.half + 4'h1;
                    end
                end
            end
            SPM_DONE:
            begin
                // Waits here while the receive FIFO is full
                if (fifo_ready)
                begin
                    next_st.buffer = cur.sr;                    // RL4
                    next_st.bf     = 1'b1;
                    next_st.irq    = 1'b1;
                    next_st.state  = SPM_IDLE;
                end
            end
            default:
            begin
                next_st.state = SPM_IDLE;
            end
        endcase

        // Clearing enable or leaving master mode resets the engine
        if (!cur.cfg.en || !master)
        begin
            next_st.state = SPM_IDLE;                           // RL9
            next_st.half  = 4'h0;
        end

        // Clock level: polarity when idle, toggles per half while shifting
        if (next_st.state == SPM_SHIFT)
        begin
            next_st.sck = next_st.cfg.pol ^
                          (next_st.cfg.cke ? next_st.half[0] : !next_st.half[0]); // RL2 RL14
        end
        else
        begin
            next_st.sck = next_st.cfg.pol;                      // RL13
        end
    end

    // State register
    always_ff @(posedge CLOCK_I)
    begin
        if (SYS_RST_I)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign S_BVALID_O = cur.bvalid;
    assign S_BRESP_O  = cur.bresp;
    assign S_RVALID_O = cur.rvalid;
    assign S_RDATA_O  = {24'h000000, cur.rdata};
    assign S_RRESP_O  = cur.rresp;
    assign SCK_O      = cur.sck;
    assign SDO_O      = cur.sr[7];
    assign SCK_OE_O   = cur.cfg.en && master && cur.cfg.dir_sck;  // RL10
    assign SDO_OE_O   = cur.cfg.en && master && cur.cfg.dir_sdo;  // RL10

    // Received bytes stream out through the FIFO
    spm_fifo #(
        .W (SPM_FIFO_W),
        .D (SPM_FIFO_D)
    ) u_rx_fifo (
        .clk_i       (CLOCK_I),
        .rst_i       (SYS_RST_I),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (cur.sr),
        .out_valid_o (RX_VALID_O),
        .out_ready_i (RX_READY_I),
        .out_data_o  (RX_DATA_O)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);

    logic [3:0] shifts_seen;

    // Counts bit shifts within one transfer
    always_ff @(posedge CLOCK_I)
    begin
        if (SYS_RST_I || cur.state == SPM_IDLE)
        begin
            shifts_seen <= 4'h0;
        end
        else if (half_tick && cur.half[0])
        begin
            shifts_seen <= shifts_seen + 4'h1;
        end
    end

    sequence s_start;
        buf_wr && !busy && cur.cfg.en && master;
    endsequence

    sequence s_finish;
        cur.state == SPM_DONE && fifo_ready && cur.cfg.en && master;
    endsequence

    property p_start;
        s_start |=> cur.state == SPM_SHIFT && SDO_O == $past(cur.w_data[7]);
    endproperty
    a_start: assert property (p_start) else $error("buffer write did not start"); // RL8

    property p_collision;
        buf_wr && cur.state == SPM_SHIFT |=> cur.write_collision_flag && $stable(cur.buffer);
    endproperty
    a_collision: assert property (p_collision) else $error("collision not flagged"); // RL5

    property p_finish;
        s_finish |=> cur.bf && cur.irq && cur.buffer == $past(cur.sr);
    endproperty
    a_finish: assert property (p_finish) else $error("completion flags wrong"); // RL4

    property p_eight;
        cur.state == SPM_DONE |-> shifts_seen == SPM_BITS;
    endproperty
    a_eight: assert property (p_eight) else $error("transfer not eight bits"); // RL1

    property p_bf_clear;
        rd_fire && S_ARADDR_I == SPM_BUF_OFS && cur.state != SPM_DONE |=> !cur.bf;
    endproperty
    a_bf_clear: assert property (p_bf_clear) else $error("buffer read kept full"); // RL6

    property p_idle_sck;
        cur.state != SPM_SHIFT |-> SCK_O == cur.cfg.pol;
    endproperty
    a_idle_sck: assert property (p_idle_sck) else $error("idle clock level wrong"); // RL13

    property p_cke_lead;
        cur.state == SPM_SHIFT && cur.half == 4'h0 && cur.cfg.cke |-> SCK_O == cur.cfg.pol;
    endproperty
    a_cke_lead: assert property (p_cke_lead) else $error("edge before data valid"); // RL14

    property p_sleep;
        SLEEP_I && cur.state == SPM_SHIFT |=> $stable(cur.half) && $stable(cur.sr);
    endproperty
    a_sleep: assert property (p_sleep) else $error("transfer moved in sleep"); // RL17

    property p_irq_hold;
        cur.irq && !(wr_fire && cur.aw_addr == SPM_FLAG_OFS) |=> cur.irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq flag dropped"); // RL18

    property p_div16;
        half_tick && cur.cfg.mode == SPM_MODE_DIV16 |=> (!half_tick) [*7];
    endproperty
    a_div16: assert property (p_div16) else $error("divide by 16 rate wrong"); // RL12

    property p_pins;
        SCK_OE_O || SDO_OE_O |-> cur.cfg.en && master;
    endproperty
    a_pins: assert property (p_pins) else $error("pins driven while not master"); // RL10
endmodule

// File: design/spm_pkg.sv
package spm_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int         SPM_AW          = 8;
    localparam logic [7:0] SPM_CTRL_OFS    = 8'h00;
    localparam logic [7:0] SPM_STAT_OFS    = 8'h04;
    localparam logic [7:0] SPM_BUF_OFS     = 8'h08;
    localparam logic [7:0] SPM_FLAG_OFS    = 8'h0c;
    localparam logic [7:0] SPM_DIR_OFS     = 8'h10;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SPM_CTRL_MODE_LSB = 0;
    localparam int SPM_CTRL_POL_BIT  = 4;
    localparam int SPM_CTRL_EN_BIT   = 5;
    localparam int SPM_CTRL_WRITE_COLLISION_FLAG_BIT = 7;
    localparam int SPM_STAT_BF_BIT   = 0;
    localparam int SPM_STAT_CKE_BIT  = 6;
    localparam int SPM_STAT_SMP_BIT  = 7;
    localparam int SPM_FLAG_IRQ_BIT  = 0;
    localparam int SPM_DIR_SDO_BIT   = 0;
    localparam int SPM_DIR_SCK_BIT   = 1;

    // ----------------------------------------------------------------
    // Timing and sizes
    // ----------------------------------------------------------------
    localparam logic [5:0] SPM_HALF_DIV4  = 6'h02;
    localparam logic [5:0] SPM_HALF_DIV16 = 6'h08;
    localparam logic [5:0] SPM_HALF_DIV64 = 6'h20;
    localparam logic [3:0] SPM_LAST_HALF  = 4'hf;
    localparam logic [3:0] SPM_BITS       = 4'h8;
    localparam int         SPM_FIFO_W     = 8;
    localparam int         SPM_FIFO_D     = 16;
    localparam logic [1:0] SPM_RESP_OKAY  = 2'h0;
    localparam logic [1:0] SPM_RESP_ERR   = 2'h2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        SPM_MODE_DIV4  = 4'b0000,
        SPM_MODE_DIV16 = 4'b0001,
        SPM_MODE_DIV64 = 4'b0010,
        SPM_MODE_TMR   = 4'b0011
    } spm_mode_t;

    typedef enum logic [1:0] {
        SPM_IDLE  = 2'b00,
        SPM_SHIFT = 2'b01,
        SPM_DONE  = 2'b10
    } spm_state_t;

    typedef struct packed {
        logic [3:0] mode;
        logic       pol;
        logic       en;
        logic       cke;
        logic       sample_phase_bit;
        logic       dir_sdo;
        logic       dir_sck;
    } spm_cfg_t;

    typedef struct packed {
        spm_cfg_t   cfg;
        logic       write_collision_flag;
        logic       bf;
        logic       irq;
        logic [7:0] buffer;
        logic [7:0] sr;
        logic       smp_bit;
        spm_state_t state;
        logic [3:0] half;
        logic [5:0] div;
        logic       sck;
        logic       aw_vld;
        logic [7:0] aw_addr;
        logic       w_vld;
        logic [7:0] w_data;
        logic       w_lane0;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } spm_regs_t;

endpackage

// File: verification/spm_slave_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// SPI slave partner
// ----------------------------------------------------------------
module spm_slave_model (
    input  wire logic       clk_i,
    input  wire logic       sck_i,
    input  wire logic       sdo_i,
    input  wire logic       pol_i,
    input  wire logic       load_i,
    input  wire logic [7:0] byte_i,
    output logic            sdi_o,
    output logic [7:0]      got_o
);
    logic       sck_q = 1'b0;
    logic [7:0] tx    = 8'h00;

    // Shifts only on edges the master makes
    always @(posedge clk_i)
    begin
        sck_q <= sck_i;
        if (load_i)
            tx <= byte_i;
        else if (sck_i != sck_q && sck_i != pol_i)
            got_o <= {got_o[6:0], sdo_i};
        else if (sck_i != sck_q)
            tx <= {tx[6:0], ~tx[7]};
    end

    assign sdi_o = tx[7];
endmodule

// File: verification/spi_master_port_bench.sv
`timescale 1ns/10ps
module spi_master_port_bench;
    import spm_pkg::*;
    logic        clk = 0, rst = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
    logic        sleep = 0, tmr = 0, rx_rdy = 1, ld = 0, pol = 0;
    logic [7:0]  awa = 0, ara = 0, ldv = 0, rx_data, got;
    logic [31:0] wd = 0, rdata, rdv, st, ctl;
    logic        awr, wr_r, bv, arr, rv, sdi, sdo, sdo_oe, sck, sck_oe, rx_valid;
    logic [1:0]  bresp, rresp, wrsp, rrsp;
    integer      seed = 32'h38c5b528, bad_count = 0, compares = 0, cyc = 0, m;
    logic [7:0]  q[$];

    spm_top DUT (.CLOCK_I(clk), .SYS_RST_I(rst), .S_AWADDR_I(awa), .S_AWVALID_I(awv),
        .S_AWREADY_O(awr), .S_WDATA_I(wd), .S_WSTRB_I(4'h1), .S_WVALID_I(wv),
        .S_WREADY_O(wr_r), .S_BRESP_O(bresp), .S_BVALID_O(bv), .S_BREADY_I(brdy),
        .S_ARADDR_I(ara), .S_ARVALID_I(arv), .S_ARREADY_O(arr), .S_RDATA_O(rdata),
        .S_RRESP_O(rresp), .S_RVALID_O(rv), .S_RREADY_I(rrdy), .SLEEP_I(sleep),
        .TIMER_TWO_I(tmr), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(sdo_oe), .SCK_O(sck),
        .SCK_OE_O(sck_oe), .RX_VALID_O(rx_valid), .RX_READY_I(rx_rdy), .RX_DATA_O(rx_data));
    // A released data-out pin shows the inverse of the port's current data-out level
    spm_slave_model PEER (.clk_i(clk), .sck_i(sck), .sdo_i(sdo_oe ? sdo : !sdo), .pol_i(pol),
        .load_i(ld), .byte_i(ldv), .sdi_o(sdi), .got_o(got));

    // ----------------------------------------------------------------
    // Clock, timer pulses, timeout
    // ----------------------------------------------------------------
    initial forever #20 clk = ~clk;
    always @(posedge clk)
    begin
        tmr <= !tmr && ($random(seed) & 1);
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            complete_run;
        end
    end

    // Received bytes leave the FIFO in order
    always @(negedge clk)
        if (rx_valid && rx_rdy)
            chk("fifo", q.pop_front(), rx_data);

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
        compares++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ao, wo, bo;
    begin
        @(posedge clk);
        awa <= a; wd <= d; awv <= 1; wv <= 1; brdy <= 1;
        ao = 0; wo = 0; bo = 0;
        while (!bo)
        begin
            @(negedge clk);
            ao = ao | awr;
            wo = wo | wr_r;
            bo = bv;
            wrsp = bresp;
            @(posedge clk);
            if (ao) awv <= 0;
            if (wo) wv <= 0;
            if (bo) brdy <= 0;
        end
    end
    endtask

    task rd(input logic [7:0] a);
        logic ao, ro;
    begin
        @(posedge clk);
        ara <= a; arv <= 1; rrdy <= 1;
        ao = 0; ro = 0;
        while (!ro)
        begin
            @(negedge clk);
            ao = ao | arr;
            ro = rv;
            rdv = rdata;
            rrsp = rresp;
            @(posedge clk);
            if (ao) arv <= 0;
            if (ro) rrdy <= 0;
        end
    end
    endtask

    task rc(input logic [7:0] a, input logic [31:0] e, input string n);
    begin
        rd(a);
        chk(n, e, rdv);
    end
    endtask

    task cfg(input logic [3:0] md, input logic p, input logic s);
    begin
        st = {24'h0, s, s, 6'h00}; // Clock-edge bit follows sample phase
        ctl = {26'h0, 1'b1, p, md};
        wr(SPM_CTRL_OFS, 0);
        wr(SPM_STAT_OFS, st);
        wr(SPM_DIR_OFS, 3);
        wr(SPM_CTRL_OFS, ctl);
        pol <= p;
        @(negedge clk);
        chk("sck_idle", p, sck);
        chk("oe", 2'b11, {sdo_oe, sck_oe});
    end
    endtask

    task xfer(input int k);
        logic [7:0] tx, rx;
        int n;
    begin
        tx = $random(seed);
        rx = $random(seed);
        @(posedge clk);
        ld <= 1; ldv <= rx;
        @(posedge clk);
        ld <= 0;
        q.push_back(rx);
        wr(SPM_BUF_OFS, {24'h0, tx});
        if (k == 1) wr(SPM_BUF_OFS, {24'h0, ~tx});
        if (k == 2)
        begin
            sleep <= 1;
            @(negedge clk);
            rdv = sck;
            n = 0;
            repeat (40) @(negedge clk) n += (sck !== rdv[0]);
            chk("sleep_hold", 0, n);
            @(posedge clk);
            sleep <= 0;
        end
        n = 0;
        rd(SPM_STAT_OFS);
        while (!rdv[0] && n++ < 400) rd(SPM_STAT_OFS);
        chk("mosi", tx ^ {8{!sdo_oe}}, got);
        rc(SPM_BUF_OFS, rx, "buf");
        rc(SPM_STAT_OFS, st, "bf_clr");
        rc(SPM_FLAG_OFS, 1, "irq");
        if (k == 1)
        begin
            rc(SPM_CTRL_OFS, ctl | 32'h80, "write_collision_flag");
            wr(SPM_CTRL_OFS, ctl);
        end
        wr(SPM_FLAG_OFS, 1);
    end
    endtask

    task complete_run;
    begin
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 0;
        rc(SPM_CTRL_OFS, 0, "ctrl_rst");
        rc(SPM_DIR_OFS, 0, "dir_rst");
        chk("oe_rst", 0, {sdo_oe, sck_oe});
        rc(8'h40, 0, "unmapped");
        chk("rd_err", SPM_RESP_ERR, rrsp);
        wr(8'h40, 32'hff);
        chk("wr_err", SPM_RESP_ERR, wrsp);
        for (m = 0; m < 4; m++)
        begin
            cfg(m[3:0], m[0], m[1]);
            xfer(0);
            xfer(m == 1 ? 1 : m == 2 ? 2 : 0);
        end
        wr(SPM_DIR_OFS, 2);
        xfer(0);
        cfg(SPM_MODE_DIV4, 0, 0);
        @(posedge clk) rx_rdy <= 0;
        repeat (16) xfer(0);
        chk("fifo_full", 1, rx_valid);
        rx_rdy <= 1;
        repeat (20) @(posedge clk);
        chk("fifo_empty", 0, rx_valid);
        wr(SPM_CTRL_OFS, 32'h24);
        @(negedge clk);
        chk("oe_slave", 0, {sdo_oe, sck_oe});
        wr(SPM_CTRL_OFS, 0);
        @(negedge clk);
        chk("oe_off", 0, {sdo_oe, sck_oe});
        complete_run;
    end
endmodule
